// ===== core/sen_error_nmi.sv
`timescale 1ns/10ps
`default_nettype none
module sen_error_nmi
  import sen_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Register access (I/O and config space)
  input  wire sen_acc_s   acc_i,
  output logic      [7:0] rdata_q,
  output logic            rvalid_q,
  // Error events
  input  wire sen_evt_s   evt_i,
  // PCI error pins, open drain, active low
  output logic            serr_n_o,
  output logic            serr_oe_q,
  output logic            perr_n_o,
  output logic            perr_oe_q,
  // Processor and management outputs
  output logic            nmi_q,
  output logic            sideband_alert_q
);

  function automatic logic hit(input sen_acc_s a, input logic io, input logic [7:0] off);
    hit = (a.io_space == io) && (a.addr == off);
  endfunction

  // Programmable state
  logic [15:0] pci_cmd_q;
  logic [7:0]  error_command_q;
  logic [7:0]  rtc_idx_q;
  logic [1:0]  pb_en_q;
  logic [15:0] pci_status_q;
  logic [7:0]  error_status_q;
  logic [1:0]  pb_flags_q;

  // Write decode
  wire wr_cmd_lo = acc_i.wr & hit(acc_i, 1'b0, CFG_CMD_LO);
  wire wr_cmd_hi = acc_i.wr & hit(acc_i, 1'b0, CFG_CMD_HI);
  wire wr_sts_lo = acc_i.wr & hit(acc_i, 1'b0, CFG_STS_LO);
  wire wr_sts_hi = acc_i.wr & hit(acc_i, 1'b0, CFG_STS_HI);
  wire wr_error_command = acc_i.wr & hit(acc_i, 1'b0, CFG_ERROR_COMMAND);
  wire wr_error_status = acc_i.wr & hit(acc_i, 1'b0, CFG_ERROR_STATUS);
  wire wr_portb  = acc_i.wr & hit(acc_i, 1'b1, IO_PORTB);
  wire wr_rtc    = acc_i.wr & hit(acc_i, 1'b1, IO_RTC_IDX);

  wire par_en   = pb_en_q[0];
  wire iochk_en = pb_en_q[1];

  // Legacy sources; ECC uncorrectable shares the parity flag so stock handlers see it
  wire       par_set   = par_en & (evt_i.mem_parity_err | evt_i.dram_ue);
  wire       iochk_set = iochk_en & evt_i.iochk_err;
  wire [1:0] pb_set    = {par_set, iochk_set};
  // Dropping an enable clears its flag, the usual legacy acknowledge
  wire [1:0] pb_clr    = {wr_portb & ~acc_i.wdata[PB_PAR_EN],
                          wr_portb & ~acc_i.wdata[PB_IOCHK_EN]};

  sen_flag_bank #(.W(2)) u_pb_flags (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set_i   (pb_set),
    .clr_i   (pb_clr),
    .flags_q (pb_flags_q)
  );

  // Error status: write one to clear
  wire [7:0] es_set;
  assign es_set[7]        = 1'b0;
  assign es_set[ES_TXDP]  = evt_i.tx_data_parity;
  assign es_set[ES_RXDP]  = evt_i.rx_data_parity;
  assign es_set[ES_ADDRP] = evt_i.addr_parity;
  assign es_set[3]        = 1'b0;
  assign es_set[ES_UE]    = evt_i.dram_ue;
  assign es_set[ES_CE]    = evt_i.dram_ce;
  assign es_set[ES_SHUT]  = evt_i.shutdown_cycle;
  wire [7:0] es_clr = wr_error_status ? acc_i.wdata : 8'h00;

  sen_flag_bank #(.W(8)) u_error_status (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set_i   (es_set),
    .clr_i   (es_clr),
    .flags_q (error_status_q)
  );

  // System error cause; processor-bus errors have no path here at all
  wire serr_cause = (error_command_q[EC_TABT]  & pci_status_q[STS_RCV_TABT])
                  | (error_command_q[EC_MABT]  & pci_status_q[STS_RCV_MABT])
                  | (error_command_q[EC_TXDP]  & error_status_q[ES_TXDP])
                  | (error_command_q[EC_RXDP]  & error_status_q[ES_RXDP])
                  | (error_command_q[EC_ADDRP] & error_status_q[ES_ADDRP])
                  | (error_command_q[EC_UE]    & error_status_q[ES_UE])
                  | evt_i.sec_serr;
  wire serr_drive = pci_cmd_q[CMD_SERR_EN] & serr_cause;
  // Secondary parity errors may arrive as retries were declined upstream
  wire perr_drive = pci_cmd_q[CMD_PERR_EN] &
                    ((error_command_q[EC_PERR] & evt_i.rx_data_parity) | evt_i.sec_perr);

  // PCI status: write one to clear per byte
  wire [15:0] ps_set;
  assign ps_set[STS_DET_PAR]  = evt_i.rx_data_parity | evt_i.addr_parity;
  assign ps_set[STS_SIG_SERR] = serr_drive;
  assign ps_set[STS_RCV_MABT] = evt_i.rcvd_master_abort;
  assign ps_set[STS_RCV_TABT] = evt_i.rcvd_target_abort;
  assign ps_set[11:9]         = 3'h0;
  assign ps_set[STS_DATA_PAR] = pci_cmd_q[CMD_PERR_EN] & evt_i.rx_data_parity;
  assign ps_set[7:0]          = 8'h00;
  wire [15:0] ps_clr = {wr_sts_hi ? acc_i.wdata : 8'h00, wr_sts_lo ? acc_i.wdata : 8'h00};

  sen_flag_bank #(.W(16)) u_pci_status (
    .ref_clk (ref_clk),
    .reset   (reset),
    .set_i   (ps_set),
    .clr_i   (ps_clr),
    .flags_q (pci_status_q)
  );

  // Interrupt request: held while a port B flag is set or system error is driven, and the index port mask bit is clear
  wire nmi_src = (|pb_flags_q) | serr_drive;
  wire nmi_d   = nmi_src & ~rtc_idx_q[RTC_NMI_MASK];

  // Read data
  wire [7:0] portb_rd = {pb_flags_q[1], pb_flags_q[0], 2'h0,
                         iochk_en, par_en, 2'h0};
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(acc_i, 1'b0, CFG_CMD_LO)) begin
      rd_mux = pci_cmd_q[7:0];
    end else if (hit(acc_i, 1'b0, CFG_CMD_HI)) begin
      rd_mux = pci_cmd_q[15:8];
    end else if (hit(acc_i, 1'b0, CFG_STS_LO)) begin
      rd_mux = pci_status_q[7:0];
    end else if (hit(acc_i, 1'b0, CFG_STS_HI)) begin
      rd_mux = pci_status_q[15:8];
    end else if (hit(acc_i, 1'b0, CFG_ERROR_COMMAND)) begin
      rd_mux = error_command_q;
    end else if (hit(acc_i, 1'b0, CFG_ERROR_STATUS)) begin
      rd_mux = error_status_q;
    end else if (hit(acc_i, 1'b1, IO_PORTB)) begin
      rd_mux = portb_rd;
    end else if (hit(acc_i, 1'b1, IO_RTC_IDX)) begin
      rd_mux = rtc_idx_q;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pci_cmd_q <= PCI_CMD_RST;
      error_command_q  <= ERROR_COMMAND_RST;
      rtc_idx_q <= RTC_IDX_RST;
      pb_en_q   <= PB_EN_RST;
    end else begin
      if (wr_cmd_lo) pci_cmd_q[7:0]  <= acc_i.wdata;
      if (wr_cmd_hi) pci_cmd_q[15:8] <= acc_i.wdata;
      if (wr_error_command) error_command_q        <= acc_i.wdata;
      if (wr_rtc)    rtc_idx_q       <= acc_i.wdata;
      if (wr_portb)  pb_en_q         <= {acc_i.wdata[PB_IOCHK_EN], acc_i.wdata[PB_PAR_EN]};
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q          <= 8'h00;
      rvalid_q         <= 1'b0;
      serr_oe_q        <= 1'b0;
      perr_oe_q        <= 1'b0;
      nmi_q            <= 1'b0;
      sideband_alert_q <= 1'b0;
    end else begin
      rdata_q          <= acc_i.rd ? rd_mux : 8'h00;
      rvalid_q         <= acc_i.rd;
      serr_oe_q        <= serr_drive;
      perr_oe_q        <= perr_drive;
      nmi_q            <= nmi_d;
      sideband_alert_q <= error_command_q[EC_CE] & error_status_q[ES_CE];
    end
  end

  // Open-drain pins only ever pull low
  assign serr_n_o = 1'b0;
  assign perr_n_o = 1'b0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  par_flag_set_a: assert property (par_en && evt_i.mem_parity_err |=> pb_flags_q[1])
    else $error("parity flag not set by enabled memory parity error");
  iochk_flag_set_a: assert property (iochk_en && evt_i.iochk_err |=> pb_flags_q[0] ##1 (pb_flags_q[0] || $past(wr_portb)))
    else $error("channel check flag not set or lost");
  iochk_block_a: assert property (!iochk_en && !pb_flags_q[0] |=> !pb_flags_q[0])
    else $error("channel check flag set while disabled");
  par_block_a: assert property (!par_en && !pb_flags_q[1] |=> !pb_flags_q[1])
    else $error("parity flag set while disabled");
  nmi_mask_a: assert property (rtc_idx_q[RTC_NMI_MASK] |=> !nmi_q)
    else $error("interrupt delivered while masked");
  nmi_raise_a: assert property (pb_flags_q != 2'h0 && !rtc_idx_q[RTC_NMI_MASK] |=> nmi_q)
    else $error("flagged legacy error did not raise interrupt");
  ecc_parity_a: assert property (par_en && evt_i.dram_ue |=> pb_flags_q[1] && error_status_q[ES_UE])
    else $error("uncorrectable ECC not shown as parity error");
  serr_gate_a: assert property (!pci_cmd_q[CMD_SERR_EN] |=> !serr_oe_q)
    else $error("system error driven while disabled");
  perr_fire_a: assert property (pci_cmd_q[CMD_PERR_EN] && error_command_q[EC_PERR] && evt_i.rx_data_parity |=> perr_oe_q)
    else $error("parity error pin not driven");
  mabt_status_a: assert property (evt_i.rcvd_master_abort |=> pci_status_q[STS_RCV_MABT])
    else $error("master abort status not set");
  shut_status_a: assert property (evt_i.shutdown_cycle |=> error_status_q[ES_SHUT])
    else $error("shutdown status not set");
  ue_serr_a: assert property (pci_cmd_q[CMD_SERR_EN] && error_command_q[EC_UE] && error_status_q[ES_UE] |=> serr_oe_q)
    else $error("uncorrectable error did not drive system error");
  tabt_serr_a: assert property (evt_i.rcvd_target_abort && error_command_q[EC_TABT] && pci_cmd_q[CMD_SERR_EN]
                                && !wr_sts_hi && !wr_error_command && !wr_cmd_hi |=> ##1 serr_oe_q)
    else $error("target abort did not drive system error");
  sec_serr_a: assert property (evt_i.sec_serr && pci_cmd_q[CMD_SERR_EN] |=> serr_oe_q && nmi_q == !$past(rtc_idx_q[RTC_NMI_MASK]))
    else $error("secondary system error not forwarded");

endmodule
`default_nettype wire

// ===== core/sen_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module sen_flag_bank
  import sen_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Set and clear vectors
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // Sticky flags
  output logic      [W-1:0] flags_q
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flag
      // Set wins over a clear in the same cycle so no event is lost
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          flags_q[g] <= 1'b0;
        end else begin
          flags_q[g] <= set_i[g] | (flags_q[g] & ~clr_i[g]);
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== dv/sen_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module sen_far_model (
  // Clock
  input  wire logic ref_clk,
  // Pin drives from the device
  input  wire logic serr_n,
  input  wire logic serr_oe,
  input  wire logic perr_n,
  input  wire logic perr_oe,
  // Master reports parity errors instead of retrying
  input  wire logic report_en,
  // Resolved lines and forwarded system error
  output logic      serr_line,
  output logic      perr_line,
  output logic      sec_serr_q
);
  // Pull-ups: a released line reads high, never the last driven value
  assign serr_line = serr_oe ? serr_n : 1'b1;
  assign perr_line = perr_oe ? perr_n : 1'b1;

  // With reporting off the master retries silently
  always_ff @(posedge ref_clk) begin
    sec_serr_q <= report_en & ~perr_line;
  end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import sen_pkg::*;
  logic       ref_clk, reset, report_en, s;
  logic       rvalid, serr_n, serr_oe, perr_n, perr_oe, nmi, alert;
  logic       serr_line, perr_line, far_serr;
  logic [7:0] rdata, d, fl, en;
  sen_acc_s   acc;
  sen_evt_s   evt, evt_all;
  int         n_fail = 0, compares = 0, seed;
  localparam int EN_BIT[7] = '{EC_TXDP, EC_RXDP, EC_ADDRP, EC_MABT, EC_TABT, EC_UE, 1};
  localparam logic [7:0] ES_EXP[7] = '{8'h40, 8'h20, 8'h10, 8'h00, 8'h00, 8'h04, 8'h01};

  sen_error_nmi DUT (.ref_clk(ref_clk), .reset(reset), .acc_i(acc), .rdata_q(rdata), .rvalid_q(rvalid),
    .evt_i(evt_all), .serr_n_o(serr_n), .serr_oe_q(serr_oe), .perr_n_o(perr_n), .perr_oe_q(perr_oe),
    .nmi_q(nmi), .sideband_alert_q(alert));
  sen_far_model far (.ref_clk(ref_clk), .serr_n(serr_n), .serr_oe(serr_oe), .perr_n(perr_n),
    .perr_oe(perr_oe), .report_en(report_en), .serr_line(serr_line), .perr_line(perr_line),
    .sec_serr_q(far_serr));

  always_comb begin
    evt_all = evt;
    evt_all.sec_serr = evt.sec_serr | (far_serr === 1'b1);
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // An idle cycle follows every access so no signal is driven twice at once
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] wd);
    acc = '{io, a, 1'b1, 1'b0, wd};
    cyc(1);
    acc = '0;
    cyc(1);
  endtask
  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] e);
    acc = '{io, a, 1'b0, 1'b1, 8'h00};
    cyc(1);
    acc = '0;
    `CHK({rvalid, rdata}, {1'b1, e})
    cyc(1);
  endtask
  task automatic pulse(input sen_evt_s e);
    evt = e;
    cyc(1);
    evt = '0;
  endtask
  function automatic sen_evt_s ev(input int k);
    sen_evt_s e = '0;
    case (k)
      0: e.tx_data_parity = 1'b1;
      1: e.rx_data_parity = 1'b1;
      2: e.addr_parity = 1'b1;
      3: e.rcvd_master_abort = 1'b1;
      4: e.rcvd_target_abort = 1'b1;
      5: e.dram_ue = 1'b1;
      6: e.shutdown_cycle = 1'b1;
      7: e.iochk_err = 1'b1;
      8: e.mem_parity_err = 1'b1;
      9: e.sec_perr = 1'b1;
      default: e.dram_ce = 1'b1;
    endcase
    return e;
  endfunction
  function automatic logic [7:0] sh_exp(input int k, input logic sg);
    return {k == 1 || k == 2, sg, k == 3, k == 4, 4'h0};
  endfunction
  task automatic end_sim();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    reset = 1'b1; acc = '0; evt = '0; report_en = 1'b0; seed = 81838;
    cyc(4);
    reset = 1'b0;
    cyc(1);
    `CHK({serr_oe, perr_oe, nmi, alert}, 4'h0)
    rd(0, CFG_CMD_HI, PCI_CMD_RST[15:8]);
    rd(0, CFG_ERROR_COMMAND, ERROR_COMMAND_RST);
    rd(1, IO_PORTB, {4'h0, PB_EN_RST, 2'h0});
    rd(1, IO_RTC_IDX, RTC_IDX_RST);
    rd(0, CFG_STS_HI, 8'h00);
    rd(1, 8'h50, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(0, CFG_ERROR_COMMAND, d);
      rd(0, CFG_ERROR_COMMAND, d);
      wr(1, IO_PORTB, d);
      rd(1, IO_PORTB, d & 8'h0c);
      wr(0, CFG_ERROR_STATUS, d);
      wr(1, 8'h50, d);
      rd(0, CFG_ERROR_STATUS, 8'h00);
    end
    wr(1, IO_PORTB, 8'h00);
    // Each error_command system error cause and the shutdown cycle, which drives none, with command bit 8 or the cause enable removed
    for (int k = 0; k < 7; k++) begin
      for (int m = 0; m < 3; m++) begin
        s = (m == 0) && (k < 6);
        wr(0, CFG_ERROR_COMMAND, (m == 2 || k == 6) ? 8'h00 : 8'h01 << EN_BIT[k]);
        wr(0, CFG_CMD_HI, {7'h00, m != 1});
        pulse(ev(k));
        cyc(3);
        `CHK({serr_line, nmi}, {~s, s})
        rd(0, CFG_ERROR_STATUS, ES_EXP[k]);
        rd(0, CFG_STS_HI, sh_exp(k, s));
        wr(0, CFG_ERROR_STATUS, 8'hff);
        wr(0, CFG_STS_HI, 8'hff);
        // An abort cause still drives system error at the first clear, and set wins
        wr(0, CFG_STS_HI, 8'hff);
        cyc(3);
        `CHK({serr_line, nmi}, 2'b10)
      end
    end
    wr(0, CFG_ERROR_COMMAND, 8'h02);
    pulse(ev(10));
    cyc(3);
    `CHK(alert, 1'b1)
    rd(0, CFG_ERROR_STATUS, 8'h02);
    wr(0, CFG_ERROR_STATUS, 8'h02);
    cyc(3);
    `CHK(alert, 1'b0)
    for (int k = 7; k < 9; k++) begin
      fl = (k == 7) ? 8'h40 : 8'h80;
      en = (k == 7) ? 8'h08 : 8'h04;
      pulse(ev(k));
      cyc(2);
      rd(1, IO_PORTB, 8'h00);
      `CHK(nmi, 1'b0)
      wr(1, IO_PORTB, en);
      pulse(ev(k));
      cyc(2);
      rd(1, IO_PORTB, fl | en);
      `CHK(nmi, 1'b1)
      wr(1, IO_RTC_IDX, 8'h80);
      cyc(1);
      `CHK(nmi, 1'b0)
      wr(1, IO_RTC_IDX, 8'h00);
      cyc(1);
      `CHK(nmi, 1'b1)
      wr(1, IO_PORTB, 8'h00);
      cyc(2);
      `CHK(nmi, 1'b0)
    end
    wr(0, CFG_ERROR_COMMAND, 8'h00);
    wr(1, IO_PORTB, 8'h04);
    pulse(ev(5));
    cyc(2);
    rd(1, IO_PORTB, 8'h84);
    wr(1, IO_PORTB, 8'h00);
    // Parity pin, then the far master turning it into a forwarded system error
    wr(0, CFG_ERROR_COMMAND, 8'h08);
    wr(0, CFG_CMD_LO, 8'h40);
    report_en = 1'b1;
    pulse(ev(1));
    `CHK(perr_line, 1'b0)
    cyc(4);
    `CHK(perr_line, 1'b1)
    rd(0, CFG_STS_HI, 8'hc1);
    rd(0, CFG_STS_LO, 8'h00);
    report_en = 1'b0;
    pulse(ev(9));
    `CHK(perr_line, 1'b0)
    cyc(1);
    wr(0, CFG_CMD_LO, 8'h00);
    pulse(ev(9));
    `CHK(perr_line, 1'b1)
    cyc(1);
    wr(0, CFG_CMD_LO, 8'h40);
    wr(0, CFG_ERROR_COMMAND, 8'h00);
    pulse(ev(1));
    `CHK(perr_line, 1'b1)
    cyc(2);
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire

// ===== include/sen_pkg.sv
package sen_pkg;

  // Register offsets (config space and I/O space)
  localparam logic [7:0] CFG_CMD_LO  = 8'h04;
  localparam logic [7:0] CFG_CMD_HI  = 8'h05;
  localparam logic [7:0] CFG_STS_LO  = 8'h06;
  localparam logic [7:0] CFG_STS_HI  = 8'h07;
  localparam logic [7:0] CFG_ERROR_COMMAND  = 8'h46;
  localparam logic [7:0] CFG_ERROR_STATUS  = 8'h47;
  localparam logic [7:0] IO_PORTB    = 8'h61;
  localparam logic [7:0] IO_RTC_IDX  = 8'h70;

  // System control port B fields
  localparam int PB_PAR_FLAG  = 7;
  localparam int PB_IOCHK_FLAG = 6;
  localparam int PB_IOCHK_EN  = 3;
  localparam int PB_PAR_EN    = 2;

  // Index port mask bit
  localparam int RTC_NMI_MASK = 7;

  // pci_command fields
  localparam int CMD_SERR_EN = 8;
  localparam int CMD_PERR_EN = 6;

  // pci_status fields
  localparam int STS_DET_PAR   = 15;
  localparam int STS_SIG_SERR  = 14;
  localparam int STS_RCV_MABT  = 13;
  localparam int STS_RCV_TABT  = 12;
  localparam int STS_DATA_PAR  = 8;

  // error_command fields
  localparam int EC_TABT  = 7;
  localparam int EC_TXDP  = 6;
  localparam int EC_RXDP  = 5;
  localparam int EC_ADDRP = 4;
  localparam int EC_PERR  = 3;
  localparam int EC_UE    = 2;
  localparam int EC_CE    = 1;
  localparam int EC_MABT  = 0;

  // error_status fields
  localparam int ES_TXDP  = 6;
  localparam int ES_RXDP  = 5;
  localparam int ES_ADDRP = 4;
  localparam int ES_UE    = 2;
  localparam int ES_CE    = 1;
  localparam int ES_SHUT  = 0;

  // Values after reset
  localparam logic [15:0] PCI_CMD_RST = 16'h0000;
  localparam logic [7:0]  ERROR_COMMAND_RST  = 8'h00;
  localparam logic [7:0]  RTC_IDX_RST = 8'h00;
  localparam logic [1:0]  PB_EN_RST   = 2'h0;

  // Register access request
  typedef struct packed {
    logic       io_space;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sen_acc_s;

  // Error events, one-cycle pulses
  typedef struct packed {
    logic iochk_err;
    logic mem_parity_err;
    logic dram_ue;
    logic dram_ce;
    logic shutdown_cycle;
    logic tx_data_parity;
    logic rx_data_parity;
    logic addr_parity;
    logic rcvd_master_abort;
    logic rcvd_target_abort;
    logic sec_serr;
    logic sec_perr;
  } sen_evt_s;

endpackage
